// *** rtl/swd_supervisor.sv ***
// Supervisor core: reset generation, watchdog, fault outputs, chip-enable gate,
// AXI4-Lite register slave and interrupt. Assumes comparator results and the
// three-level kick input arrive as synchronous digital levels.
// How it works
// [RL1] Reset stays low while manual reset is low and 200 ms after it rises.
// [RL2] Timeout is 1.6 s with select high, else 2.1 ms per nF of capacitor.
// [RL3] Warning output goes low when supply nears reset threshold plus 150 mV.
// [RL4] Kick steady past timeout drives fault low until the next kick change.
// [RL5] Kick at mid level disables the watchdog and holds fault high.
// [RL6] Gated chip enable follows input only when up; grace 15 us on reset.
// [RL7] Fault output is forced high while system reset is asserted.
// [RL8] Reset asserts while supply is low and holds 200 ms after it recovers.
// [RL9] Timeout pulses fault-pulse low at least 1 ms, 70 ns before fault.
// [RL10] Manual reset low 15 us clears counters, sets faults high, blocks enable.
// [RL11] Reset follows the supply and manual-reset comparator results.
// [RL12] Battery switchover has no path into reset generation.
// [RL13] Any kick edge or short pulse restarts the watchdog period.
// [RL14] Supply low disables watchdog and disconnects the kick bias network.
// [RL15] Outside flip-flop may chain fault pulse and fault for double-fault latch.
// [RL16] Kick comes as high, low, mid flags; edges only seen when not mid.
// [RL17] On power-up chip enable stays blocked until reset deasserts.
`timescale 1ns/100ps
module swd_supervisor
   import swd_pkg::*;
#(
   parameter int RST_HOLD       = RST_HOLD_CYC,
   parameter int WDT_DEF        = WDT_DEF_CYC,
   parameter int WDT_CAP_PER_NF = WDT_CAP_CYC_PER_NF,
   parameter int FLT_PULSE      = FLT_PULSE_CYC
)
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Supply comparators
   input  wire logic       supply_low_in,
   input  wire logic       supply_warn_in,
   // Manual reset and timeout select
   input  wire logic       manual_reset_n_in,
   input  wire logic       timeout_select_in,
   // Three-level kick input
   input  wire logic       kick_in_hi,
   input  wire logic       kick_in_lo,
   input  wire logic       kick_in_mid,
   // Chip-enable gate
   input  wire logic       ce_n_in,
   output logic            ce_n_out,
   // Supervisor outputs
   output logic            reset_n_out,
   output logic            supply_warning_n_out,
   output logic            fault_n_out,
   output logic            fault_pulse_n_out,
   output logic            kick_bias_en_out,
   output logic            irq,
   // AXI4-Lite slave
   input  wire logic       s_axi_awvalid,
   output logic            s_axi_awready,
   input  wire logic [7:0] s_axi_awaddr,
   input  wire logic       s_axi_wvalid,
   output logic            s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0] s_axi_wstrb,
   output logic            s_axi_bvalid,
   input  wire logic       s_axi_bready,
   output logic [1:0]      s_axi_bresp,
   input  wire logic       s_axi_arvalid,
   output logic            s_axi_arready,
   input  wire logic [7:0] s_axi_araddr,
   output logic            s_axi_rvalid,
   input  wire logic       s_axi_rready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp
);

   swd_tmr_if   tmr ();
   swd_ce_type  ce_st_ff;
   logic [31:0] hold_cnt_ff;
   logic [31:0] pulse_cnt_ff;
   logic [3:0]  gap_cnt_ff;
   logic [10:0] ce_cnt_ff;
   logic [10:0] mr_cnt_ff;
   logic        mr_long_ff;
   logic        kick_lvl_ff;
   logic        reset_n_ff;
   logic        warn_n_ff;
   logic        fault_n_ff;
   logic        fpulse_n_ff;
   logic        ce_n_ff;
   logic        bias_ff;
   logic        irq_ff;
   logic [7:0]  cap_ff;
   logic [EV_W-1:0] mask_ff;
   logic [EV_W-1:0] status_ff;
   logic        aw_hold_ff;
   logic        w_hold_ff;
   logic [7:0]  aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        awready_ff;
   logic        wready_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        rst_src_c;
   logic        rst_c;
   logic        kick_lvl_c;
   logic        kick_edge_c;
   logic        wd_run_c;
   logic        timeout_c;
   logic        aw_take;
   logic        w_take;
   logic        wr_go;
   logic        ar_take;
   logic        rd_clr;
   logic [EV_W-1:0] ev_set;

   // Reset sources: supply comparator and manual-reset comparator only
   assign rst_src_c = supply_low_in || !manual_reset_n_in; // [RL11] [RL12]
   assign rst_c     = rst_src_c || (hold_cnt_ff != 32'h0000_0000);

   // Kick level from the high and low indications; mid masks edges
   assign kick_lvl_c  = kick_in_hi && !kick_in_lo;
   assign kick_edge_c = !kick_in_mid && (kick_lvl_c != kick_lvl_ff); // [RL16]
   assign wd_run_c    = !rst_c && !kick_in_mid; // [RL5] [RL14]
   assign timeout_c   = tmr.expired && wd_run_c;

   // Period counter hookup; period picked by the select pin
   assign tmr.load   = kick_edge_c; // [RL13]
   assign tmr.run    = wd_run_c;
   assign tmr.period = timeout_select_in ? 32'(WDT_DEF) :
                       ((cap_ff == 8'h00) ? 32'h0000_0001 :
                        32'(cap_ff) * 32'(WDT_CAP_PER_NF)); // [RL2]

   swd_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tmr     (tmr.tmr)
   );

   // Reset hold-off: reload while a source is active, then count out
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hold_cnt_ff <= 32'(RST_HOLD);
      else if (rst_src_c)
         hold_cnt_ff <= 32'(RST_HOLD); // [RL1] [RL8]
      else if (hold_cnt_ff != 32'h0000_0000)
         hold_cnt_ff <= hold_cnt_ff - 32'h0000_0001;
   end

   // Reset, warning and bias outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reset_n_ff <= 1'b0;
         warn_n_ff  <= 1'b0;
         bias_ff    <= 1'b0;
      end
      else
      begin
         reset_n_ff <= !rst_c; // [RL1] [RL8] [RL11]
         warn_n_ff  <= !supply_warn_in; // [RL3]
         bias_ff    <= !supply_low_in; // [RL14]
      end
   end

   // Long manual-reset detector
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mr_cnt_ff  <= 11'h000;
         mr_long_ff <= 1'b0;
      end
      else if (manual_reset_n_in)
      begin
         mr_cnt_ff  <= 11'h000;
         mr_long_ff <= 1'b0;
      end
      else if (mr_cnt_ff == 11'(MR_MIN_CYC - 1))
         mr_long_ff <= 1'b1; // [RL10]
      else
         mr_cnt_ff <= mr_cnt_ff + 11'h001;
   end

   // Last seen kick level, tracked only outside mid level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         kick_lvl_ff <= 1'b0;
      else if (!kick_in_mid)
         kick_lvl_ff <= kick_lvl_c; // [RL16]
   end

   // Fault pulse, then fault level after the gap; kicks release the level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fault_n_ff   <= 1'b1;
         fpulse_n_ff  <= 1'b1;
         pulse_cnt_ff <= 32'h0000_0000;
         gap_cnt_ff   <= 4'h0;
      end
      else if (rst_c || kick_in_mid)
      begin
         fault_n_ff   <= 1'b1; // [RL5] [RL7] [RL10] [RL14]
         fpulse_n_ff  <= 1'b1;
         pulse_cnt_ff <= 32'h0000_0000;
         gap_cnt_ff   <= 4'h0;
      end
      else
      begin
         if (timeout_c)
         begin
            fpulse_n_ff  <= 1'b0; // [RL9]
            pulse_cnt_ff <= 32'(FLT_PULSE) - 32'h0000_0001;
         end
         else if (pulse_cnt_ff != 32'h0000_0000)
            pulse_cnt_ff <= pulse_cnt_ff - 32'h0000_0001;
         else
            fpulse_n_ff <= 1'b1;
         // Fault level lags the pulse edge; data for an outside latch
         if (kick_edge_c)
         begin
            fault_n_ff <= 1'b1; // [RL4] [RL13]
            gap_cnt_ff <= 4'h0;
         end
         else if (timeout_c)
            gap_cnt_ff <= 4'(FLT_GAP_CYC); // [RL9] [RL15]
         else if (gap_cnt_ff == 4'h1)
         begin
            fault_n_ff <= 1'b0; // [RL4] [RL9]
            gap_cnt_ff <= 4'h0;
         end
         else if (gap_cnt_ff != 4'h0)
            gap_cnt_ff <= gap_cnt_ff - 4'h1;
      end
   end

   // Chip-enable gate state machine
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ce_st_ff  <= CE_OFF;
         ce_cnt_ff <= 11'h000;
      end
      else
      begin
         unique case (ce_st_ff)
            CE_OFF:
               if (!rst_c)
                  ce_st_ff <= CE_PASS; // [RL17]
            CE_PASS:
               if (rst_c)
               begin
                  ce_st_ff  <= (!ce_n_in && !mr_long_ff) ? CE_GRACE : CE_OFF; // [RL6]
                  ce_cnt_ff <= 11'(CE_HOLD_CYC - 1);
               end
            CE_GRACE:
               if (ce_n_in || mr_long_ff || ce_cnt_ff == 11'h000)
                  ce_st_ff <= CE_OFF; // [RL6] [RL10]
               else
                  ce_cnt_ff <= ce_cnt_ff - 11'h001;
            default:
               ce_st_ff <= CE_OFF;
         endcase
      end
   end

   // Gated output: passes only when enabled or within grace
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ce_n_ff <= 1'b1;
      else if (mr_long_ff || ce_st_ff == CE_OFF)
         ce_n_ff <= 1'b1; // [RL10] [RL17]
      else
         ce_n_ff <= ce_n_in; // [RL6]
   end

   // AXI4-Lite handshake decode
   assign aw_take = s_axi_awvalid && awready_ff;
   assign w_take  = s_axi_wvalid && wready_ff;
   assign wr_go   = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign ar_take = s_axi_arvalid && arready_ff;
   assign rd_clr  = ar_take && (s_axi_araddr == ADDR_STATUS);

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
            aw_addr_ff <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         aw_hold_ff <= (aw_hold_ff || aw_take) && !wr_go;
         w_hold_ff  <= (w_hold_ff || w_take) && !wr_go;
         awready_ff <= !((aw_hold_ff || aw_take) && !wr_go);
         wready_ff  <= !((w_hold_ff || w_take) && !wr_go);
         if (wr_go)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (aw_addr_ff == ADDR_CAP || aw_addr_ff == ADDR_STATUS ||
                          aw_addr_ff == ADDR_MASK || aw_addr_ff == ADDR_LIVE) ?
                         RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   // Writable registers: capacitor value and interrupt mask
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_ff  <= CAP_RST;
         mask_ff <= MASK_RST;
      end
      else if (wr_go && w_strb_ff[0])
      begin
         if (aw_addr_ff == ADDR_CAP)
            cap_ff <= w_data_ff[7:0]; // [RL2]
         if (aw_addr_ff == ADDR_MASK)
            mask_ff <= w_data_ff[EV_W-1:0];
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_CAP:    rdata_ff <= {24'h000000, cap_ff};
            ADDR_STATUS: rdata_ff <= {28'h0000000, status_ff};
            ADDR_MASK:   rdata_ff <= {28'h0000000, mask_ff};
            ADDR_LIVE:   rdata_ff <= {26'h0, wd_run_c, ce_st_ff == CE_PASS,
                                      fpulse_n_ff, fault_n_ff, warn_n_ff, reset_n_ff};
            default:
            begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // Sticky events; a new event beats the read clear
   always_comb
   begin
      ev_set             = '0;
      ev_set[EV_TIMEOUT] = timeout_c;
      ev_set[EV_RESET]   = rst_c && reset_n_ff;
      ev_set[EV_MRLONG]  = !manual_reset_n_in && mr_cnt_ff == 11'(MR_MIN_CYC - 1) &&
                           !mr_long_ff;
      ev_set[EV_SUPPLY_WARNING_N_OUT] = supply_warn_in && warn_n_ff;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_ff <= '0;
         irq_ff    <= 1'b0;
      end
      else
      begin
         status_ff <= (rd_clr ? '0 : status_ff) | ev_set;
         irq_ff    <= |(((rd_clr ? '0 : status_ff) | ev_set) & mask_ff);
      end
   end

   // Outputs straight from flops
   assign reset_n_out          = reset_n_ff;
   assign supply_warning_n_out = warn_n_ff;
   assign fault_n_out          = fault_n_ff;
   assign fault_pulse_n_out    = fpulse_n_ff;
   assign ce_n_out             = ce_n_ff;
   assign kick_bias_en_out     = bias_ff;
   assign irq                  = irq_ff;
   assign s_axi_awready        = awready_ff;
   assign s_axi_wready         = wready_ff;
   assign s_axi_bvalid         = bvalid_ff;
   assign s_axi_bresp          = bresp_ff;
   assign s_axi_arready        = arready_ff;
   assign s_axi_rvalid         = rvalid_ff;
   assign s_axi_rdata          = rdata_ff;
   assign s_axi_rresp          = rresp_ff;

   // Checks on the outputs against their causes
   property p_mr_reset;
      @(posedge aclk) disable iff (!aresetn)
      !manual_reset_n_in |=> !reset_n_ff;
   endproperty
   a_mr_reset: assert property (p_mr_reset) else $error("Reset not low with manual reset"); // [RL1]

   property p_supply_reset;
      @(posedge aclk) disable iff (!aresetn)
      supply_low_in |=> !reset_n_ff ##1 !reset_n_ff;
   endproperty
   a_supply_reset: assert property (p_supply_reset) else $error("Reset not held on low supply"); // [RL8]

   property p_warn;
      @(posedge aclk) disable iff (!aresetn)
      supply_warn_in |=> !warn_n_ff;
   endproperty
   a_warn: assert property (p_warn) else $error("Warning output not low"); // [RL3]

   property p_fault_hold;
      @(posedge aclk) disable iff (!aresetn)
      !fault_n_ff && !kick_edge_c && !kick_in_mid && !rst_c |=> !fault_n_ff;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("Fault released without kick"); // [RL4]

   property p_mid_off;
      @(posedge aclk) disable iff (!aresetn)
      kick_in_mid |=> fault_n_ff && fpulse_n_ff;
   endproperty
   a_mid_off: assert property (p_mid_off) else $error("Fault active with kick at mid"); // [RL5]

   property p_ce_release;
      @(posedge aclk) disable iff (!aresetn)
      !reset_n_ff && ce_n_in |=> ce_n_ff;
   endproperty
   a_ce_release: assert property (p_ce_release) else $error("Gated enable low after release"); // [RL6]

   property p_rst_fault;
      @(posedge aclk) disable iff (!aresetn)
      !reset_n_ff |-> fault_n_ff;
   endproperty
   a_rst_fault: assert property (p_rst_fault) else $error("Fault low during reset"); // [RL7]

   property p_pulse_lead;
      @(posedge aclk) disable iff (!aresetn)
      $fell(fpulse_n_ff) ##1 (!rst_c && !kick_in_mid && !kick_edge_c)[*8] |=> !fault_n_ff;
   endproperty
   a_pulse_lead: assert property (p_pulse_lead) else $error("Fault did not follow pulse"); // [RL9]

   property p_mr_long;
      @(posedge aclk) disable iff (!aresetn)
      mr_long_ff |=> ce_n_ff && fault_n_ff && fpulse_n_ff;
   endproperty
   a_mr_long: assert property (p_mr_long) else $error("Long manual reset not applied"); // [RL10]

   property p_kick_restart;
      @(posedge aclk) disable iff (!aresetn)
      kick_edge_c && !rst_c |=> fault_n_ff;
   endproperty
   a_kick_restart: assert property (p_kick_restart) else $error("Kick did not clear fault"); // [RL13]

   property p_bias_off;
      @(posedge aclk) disable iff (!aresetn)
      supply_low_in |=> !bias_ff;
   endproperty
   a_bias_off: assert property (p_bias_off) else $error("Kick bias still on"); // [RL14]

   // Main scenarios
   c_timeout: cover property (@(posedge aclk) disable iff (!aresetn) $fell(fpulse_n_ff));
   c_ce_grace: cover property (@(posedge aclk) disable iff (!aresetn)
      ce_st_ff == CE_GRACE ##1 ce_st_ff == CE_OFF);
   c_rst_release: cover property (@(posedge aclk) disable iff (!aresetn) $rose(reset_n_ff));

endmodule : swd_supervisor

// *** rtl/swd_pkg.sv ***
// Shared constants, register map and state types for the supervisor block.
// Assumes a single 125 MHz clock; all times are turned into cycle counts here.
package swd_pkg;

   // Clock rate in kHz, so that ms * CLK_KHZ gives cycles
   localparam int CLK_KHZ            = 125000;

   // Reset hold-off after the last reset source clears
   localparam int RST_HOLD_MS        = 200;
   localparam int RST_HOLD_CYC       = RST_HOLD_MS * CLK_KHZ;
   // Default watchdog period, and period per nF of timing capacitor
   localparam int WDT_DEF_MS         = 1600;
   localparam int WDT_DEF_CYC        = WDT_DEF_MS * CLK_KHZ;
   localparam int WDT_CAP_US_PER_NF  = 2100;
   localparam int WDT_CAP_CYC_PER_NF = (WDT_CAP_US_PER_NF * CLK_KHZ) / 1000;
   // Fault pulse width (least) and its lead over the fault level
   localparam int FLT_PULSE_MS       = 1;
   localparam int FLT_PULSE_CYC      = FLT_PULSE_MS * CLK_KHZ;
   localparam int FLT_GAP_NS         = 70;
   localparam int FLT_GAP_CYC        = (FLT_GAP_NS * CLK_KHZ + 999999) / 1000000;
   // Chip-enable grace after reset (longest, rounds down)
   localparam int CE_HOLD_US         = 15;
   localparam int CE_HOLD_CYC        = (CE_HOLD_US * CLK_KHZ) / 1000;
   // Least manual-reset low time that clears the block (rounds up)
   localparam int MR_MIN_US          = 15;
   localparam int MR_MIN_CYC         = (MR_MIN_US * CLK_KHZ + 999) / 1000;

   // Register byte offsets
   localparam logic [7:0] ADDR_CAP    = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK   = 8'h08;
   localparam logic [7:0] ADDR_LIVE   = 8'h0c;

   // Event bit positions in status and mask
   localparam int EV_TIMEOUT = 0;
   localparam int EV_RESET   = 1;
   localparam int EV_MRLONG  = 2;
   localparam int EV_SUPPLY_WARNING_N_OUT = 3;
   localparam int EV_W       = 4;

   // Reset values
   localparam logic [7:0]      CAP_RST  = 8'h0a;
   localparam logic [EV_W-1:0] MASK_RST = 4'h0;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Chip-enable gate states
   typedef enum logic [1:0] {
      CE_OFF   = 2'b00,
      CE_PASS  = 2'b01,
      CE_GRACE = 2'b10
   } swd_ce_type;

endpackage : swd_pkg

// *** rtl/swd_tmr_if.sv ***
// Link between the supervisor core and its watchdog period counter.
// Assumes both ends share aclk.
`timescale 1ns/100ps
interface swd_tmr_if;
   logic        load;     // Restart the period
   logic        run;      // Count while high
   logic [31:0] period;   // Period in cycles
   logic        expired;  // One-cycle pulse at period end

   modport ctl (output load, output run, output period, input expired);
   modport tmr (input load, input run, input period, output expired);
endinterface : swd_tmr_if

// *** rtl/swd_timer.sv ***
// Watchdog period counter: reloads on request, pulses at each period end.
// Assumes period is at least one cycle and steady while running.
`timescale 1ns/100ps
module swd_timer
   import swd_pkg::*;
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control from the core
   swd_tmr_if.tmr    tmr
);

   logic [31:0] cnt_ff;
   logic        exp_ff;

   // Count down, reload at zero and flag the end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_ff <= 32'h0000_0000;
         exp_ff <= 1'b0;
      end
      else if (tmr.load || !tmr.run || cnt_ff == 32'h0000_0000)
      begin
         cnt_ff <= tmr.period - 32'h0000_0001;
         exp_ff <= tmr.run && !tmr.load;
      end
      else
      begin
         cnt_ff <= cnt_ff - 32'h0000_0001;
         exp_ff <= 1'b0;
      end
   end

   assign tmr.expired = exp_ff;

endmodule : swd_timer

// *** tb/swd_host_model.sv ***
// Host model: kicks the watchdog line and keeps an outside double-fault latch.
// Assumes it shares aclk with the supervisor.
`timescale 1ns/100ps
module swd_host_model
#(
   parameter int KICK_GAP = 20
)
(
   // Clock
   input  wire logic aclk,
   // Bench control
   input  wire logic run,
   input  wire logic float_en,
   // Supervisor outputs
   input  wire logic fault_n_out,
   input  wire logic fault_pulse_n_out,
   // Kick levels and latch
   output logic      kick_in_hi,
   output logic      kick_in_lo,
   output logic      kick_in_mid,
   output logic      shut_n_ff
);
   int   cnt_ff = 0;
   logic lvl_ff = 1'h0;
   logic pls_ff = 1'h1;
   // Toggle the kick level every KICK_GAP+1 cycles while running
   always_ff @(posedge aclk)
   begin
      cnt_ff <= (cnt_ff >= KICK_GAP) ? 0 : cnt_ff + 1;
      if (run && cnt_ff == KICK_GAP)
         lvl_ff <= !lvl_ff;
   end
   // A floating line shows only the mid flag
   assign kick_in_hi  = lvl_ff && !float_en;
   assign kick_in_lo  = !lvl_ff && !float_en;
   assign kick_in_mid = float_en;
   // Latch clocked by the pulse falling edge, fault level as data
   always @(posedge aclk)
   begin
      pls_ff <= fault_pulse_n_out;
      if (pls_ff && !fault_pulse_n_out)
         shut_n_ff <= fault_n_out;
   end
   initial shut_n_ff = 1'h1;
endmodule : swd_host_model

// *** tb/swd_supervisor_tb.sv ***
// Self-checking bench for the supervisor core with a small-count build.
// Assumes the host model drives the kick flags.
`timescale 1ns/100ps
module swd_supervisor_tb;
   import swd_pkg::*;
   localparam int HOLD = 50, WDT = 200, PNF = 20, PLS = 30;
   logic aclk = 0, aresetn = 0, supply_low_in = 0, supply_warn_in = 0, manual_reset_n_in = 1;
   logic timeout_select_in = 1, ce_n_in = 0, run = 0, float_en = 0, ok;
   logic kick_in_hi, kick_in_lo, kick_in_mid, ce_n_out, reset_n_out, supply_warning_n_out;
   logic fault_n_out, fault_pulse_n_out, kick_bias_en_out, irq, shut_n_ff;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   int          checks = 0, n_mismatch = 0, cyc = 0, n;

   swd_supervisor #(.RST_HOLD(HOLD), .WDT_DEF(WDT), .WDT_CAP_PER_NF(PNF), .FLT_PULSE(PLS))
   u_swd_supervisor (.aclk, .aresetn, .supply_low_in, .supply_warn_in, .manual_reset_n_in,
      .timeout_select_in, .kick_in_hi, .kick_in_lo, .kick_in_mid, .ce_n_in, .ce_n_out,
      .reset_n_out, .supply_warning_n_out, .fault_n_out, .fault_pulse_n_out,
      .kick_bias_en_out, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp);
   swd_host_model u_swd_host_model (.aclk, .run, .float_en, .fault_n_out, .fault_pulse_n_out,
      .kick_in_hi, .kick_in_lo, .kick_in_mid, .shut_n_ff);

   // Clock and hang guard
   initial
      forever #4 aclk = !aclk;
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      chk_word(nm, {31'h0, exp}, {31'h0, got});
   endtask : chk_bit
   task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask : chk_word
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask : tick
   // Write: AW and W offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic wait_pulse();
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end while (fault_pulse_n_out !== 1'h0);
   endtask : wait_pulse
   task automatic wrap_up();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // Main sequence
   initial
   begin
      tick(5);
      aresetn <= 1'h1;
      tick(HOLD - 2);
      chk_bit("reset hold", 0, reset_n_out);
      chk_bit("ce power-up", 1, ce_n_out);
      chk_bit("fault in reset", 1, fault_n_out);
      tick(10);
      chk_bit("reset end", 1, reset_n_out);
      chk_bit("ce pass", 0, ce_n_out);
      rd(ADDR_CAP);
      chk_word("cap", 32'(CAP_RST), d);
      rd(ADDR_MASK);
      chk_word("mask", 32'h0, d);
      rd(8'h10);
      chk_word("unmapped", 32'(RESP_SLVERR), 32'(r));
      wr(ADDR_LIVE, 32'hff);
      chk_word("live wr", 32'(RESP_OKAY), 32'(r));
      rd(ADDR_STATUS);
      wr(ADDR_MASK, 32'h1 << EV_TIMEOUT);
      run <= 1'h1;
      tick(300);
      chk_bit("kicked", 1, fault_n_out);
      for (int i = 0; i < 2; i++)
      begin
         timeout_select_in <= (i == 0);
         wr(ADDR_CAP, 32'h4);
         tick(50);
         run <= 1'h0;
         wait_pulse();
         chk_bit("period", 1, (n - (i ? 4 * PNF : WDT)) inside {[-24:7]});
         chk_bit("fault lead", 1, fault_n_out);
         tick(12);
         chk_bit("fault low", 0, fault_n_out);
         n = 12;
         while (fault_pulse_n_out === 1'h0)
         begin
            @(posedge aclk);
            n++;
         end
         chk_word("pulse width", PLS, n);
         chk_bit("irq set", 1, irq);
         rd(ADDR_STATUS);
         chk_bit("status", 1, d[EV_TIMEOUT]);
         tick(2);
         chk_bit("irq clr", 0, irq);
         wait_pulse();
         tick(1);
         chk_bit("latch", 0, shut_n_ff);
         run <= 1'h1;
         tick(45);
         chk_bit("fault cleared", 1, fault_n_out);
      end
      float_en <= 1'h1;
      ok = 1'h1;
      repeat (400)
      begin
         @(posedge aclk);
         ok &= fault_n_out & fault_pulse_n_out;
      end
      chk_bit("mid idle", 1, ok);
      float_en <= 1'h0;
      manual_reset_n_in <= 1'h0;
      tick(3);
      chk_bit("mr reset", 0, reset_n_out);
      chk_bit("ce grace", 0, ce_n_out);
      tick(2000);
      chk_bit("mr ce", 1, ce_n_out);
      chk_bit("mr pulse", 1, fault_pulse_n_out);
      manual_reset_n_in <= 1'h1;
      tick(HOLD - 2);
      chk_bit("mr hold", 0, reset_n_out);
      tick(10);
      chk_bit("mr end", 1, reset_n_out);
      supply_warn_in <= 1'h1;
      tick(3);
      chk_bit("warning", 0, supply_warning_n_out);
      supply_low_in <= 1'h1;
      tick(3);
      chk_bit("low reset", 0, reset_n_out);
      chk_bit("bias off", 0, kick_bias_en_out);
      ce_n_in <= 1'h1;
      tick(2);
      chk_bit("ce release", 1, ce_n_out);
      supply_low_in <= 1'h0;
      supply_warn_in <= 1'h0;
      tick(HOLD + 10);
      chk_bit("low end", 1, reset_n_out);
      wrap_up();
   end
endmodule : swd_supervisor_tb
